/* rtl/dcl_code_clamp.sv */
`timescale 1ns/10ps
module dcl_code_clamp
  import dcl_pkg::*;
(
  input wire logic [DCL_CODE_W-1:0] code_in,
  input wire logic [DCL_LIM_W-1:0] ceil_field,
  output logic [DCL_CODE_W-1:0] code_out,
  output logic clipped
);

  logic [DCL_CODE_W-1:0] ceiling;

  // field n gives n followed by seven ones, 007f up to 1fff
  assign ceiling = {ceil_field, DCL_CEIL_FILL};
  // above the ceiling gives the ceiling, else passes through (no storage here)
  assign clipped = (code_in > ceiling);
  assign code_out = clipped ? ceiling : code_in;

endmodule : dcl_code_clamp

/* rtl/dcl_pkg.sv */
package dcl_pkg;

  localparam int DCL_NCH = 8;
  localparam int DCL_CODE_W = 13;
  localparam int DCL_LIM_W = 6;
  localparam int DCL_FILL_W = DCL_CODE_W - DCL_LIM_W;
  localparam int DCL_ADDR_W = 12;
  localparam int DCL_DATA_W = 32;
  localparam int DCL_REG_W = 16;

  // register indexes; the byte address is four times the index
  localparam logic [7:0] DCL_IDX_CEIL_A_LO = 8'h4c;
  localparam logic [7:0] DCL_IDX_CEIL_A_HI = 8'h4d;
  localparam logic [7:0] DCL_IDX_CEIL_B_LO = 8'h4e;
  localparam logic [7:0] DCL_IDX_CEIL_B_HI = 8'h4f;
  localparam logic [7:0] DCL_IDX_PIN0_MASK = 8'h50;
  localparam logic [7:0] DCL_IDX_PIN1_MASK = 8'h51;
  localparam logic [7:0] DCL_IDX_BUF_BASE = 8'h40;
  localparam logic [7:0] DCL_IDX_LOAD = 8'h53;
  localparam logic [7:0] DCL_IDX_STATUS = 8'h54;
  localparam logic [7:0] DCL_IDX_ACT_BASE = 8'h60;

  // field positions
  localparam int DCL_CEIL_LO_LSB = 0;
  localparam int DCL_CEIL_HI_LSB = 8;
  localparam int DCL_STAT_SW_LSB = 0;
  localparam int DCL_STAT_PIN0_BIT = 8;
  localparam int DCL_STAT_PIN1_BIT = 9;
  localparam int DCL_STAT_CLIP_LSB = 16;

  // reset values, then the fixed fill below each ceiling field
  localparam logic [15:0] DCL_CEIL_REG_RST = 16'h3f3f;
  localparam logic [DCL_LIM_W-1:0] DCL_CEIL_FIELD_RST = 6'h3f;
  localparam logic [7:0] DCL_MASK_RST = 8'h00;
  localparam logic [DCL_CODE_W-1:0] DCL_CODE_RST = 13'h0000;
  localparam logic [DCL_FILL_W-1:0] DCL_CEIL_FILL = 7'h7f;

  typedef enum logic [2:0] {
    DCL_R_NONE  = 3'h0,
    DCL_R_CEIL  = 3'h1,
    DCL_R_MASK0 = 3'h3,
    DCL_R_MASK1 = 3'h2,
    DCL_R_BUF   = 3'h6,
    DCL_R_LOAD  = 3'h7,
    DCL_R_STAT  = 3'h5,
    DCL_R_ACT   = 3'h4
  } dcl_reg_e;

endpackage : dcl_pkg

/* rtl/dcl_regs.sv */
`timescale 1ns/10ps
module dcl_regs
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DCL_ADDR_W-1:0] paddr,
  input wire logic [DCL_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DCL_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic switch_ctrl_pin_zero,
  input wire logic switch_ctrl_pin_one,
  output logic [DCL_NCH-1:0] switch_on,
  output logic [DCL_NCH*DCL_CODE_W-1:0] active_code
);

  function automatic logic [7:0] dcl_index(input logic [DCL_ADDR_W-1:0] a);
    dcl_index = a[9:2];
  endfunction : dcl_index

  // unaligned words and addresses beyond the index range decode to none
  function automatic dcl_reg_e dcl_decode(input logic [DCL_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    dcl_decode = DCL_R_NONE;
    if (a[1:0] == 2'h0 && a[DCL_ADDR_W-1:10] == '0) begin
      if (idx >= DCL_IDX_CEIL_A_LO && idx <= DCL_IDX_CEIL_B_HI) begin
        dcl_decode = DCL_R_CEIL;
      end else if (idx == DCL_IDX_PIN0_MASK) begin
        dcl_decode = DCL_R_MASK0;
      end else if (idx == DCL_IDX_PIN1_MASK) begin
        dcl_decode = DCL_R_MASK1;
      end else if (idx[7:3] == DCL_IDX_BUF_BASE[7:3]) begin
        dcl_decode = DCL_R_BUF;
      end else if (idx == DCL_IDX_LOAD) begin
        dcl_decode = DCL_R_LOAD;
      end else if (idx == DCL_IDX_STATUS) begin
        dcl_decode = DCL_R_STAT;
      end else if (idx[7:3] == DCL_IDX_ACT_BASE[7:3]) begin
        dcl_decode = DCL_R_ACT;
      end
    end
  endfunction : dcl_decode

  // byte-lane merge of the low 16 bits
  function automatic logic [DCL_REG_W-1:0] dcl_merge(
    input logic [DCL_REG_W-1:0] old_v,
    input logic [DCL_DATA_W-1:0] wd,
    input logic [3:0] st
  );
    dcl_merge = old_v;
    if (st[0]) begin
      dcl_merge[7:0] = wd[7:0];
    end
    if (st[1]) begin
      dcl_merge[15:8] = wd[15:8];
    end
  endfunction : dcl_merge

  logic [DCL_LIM_W-1:0] ceil_r [DCL_NCH];
  logic [DCL_NCH-1:0] pin0_mask_r;
  logic [DCL_NCH-1:0] pin1_mask_r;
  logic [DCL_CODE_W-1:0] buf_r [DCL_NCH];
  logic [DCL_CODE_W-1:0] act_r [DCL_NCH];
  logic [DCL_CODE_W-1:0] clamped [DCL_NCH];
  logic [DCL_NCH-1:0] clip_now;
  logic [DCL_NCH-1:0] clip_r;
  logic [DCL_NCH-1:0] sw_r;
  logic [DCL_DATA_W-1:0] prdata_r;
  logic [DCL_DATA_W-1:0] rd_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [1:0] pins_sync;
  logic pin0_s;
  logic pin1_s;
  dcl_reg_e acc_kind;
  logic [7:0] acc_idx;
  logic [2:0] acc_ch;
  logic [1:0] ceil_pair;
  logic setup_phase;
  logic wr_take;
  logic [DCL_REG_W-1:0] ceil_word;
  logic [DCL_REG_W-1:0] ceil_new;
  logic [DCL_REG_W-1:0] mask_new;
  logic [DCL_REG_W-1:0] buf_new;
  logic [DCL_REG_W-1:0] load_new;

  assign acc_kind = dcl_decode(paddr);
  assign acc_idx = dcl_index(paddr);
  assign acc_ch = acc_idx[2:0];
  assign ceil_pair = 2'(acc_idx - DCL_IDX_CEIL_A_LO);
  assign setup_phase = psel && !penable;
  // a write lands only at the edge where the master sees pready high
  assign wr_take = psel && penable && pready_r && pwrite;

  // pin levels are asynchronous; two flops before any use
  dcl_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({switch_ctrl_pin_one, switch_ctrl_pin_zero}),
    .sync_out(pins_sync)
  );
  assign pin0_s = pins_sync[0];
  assign pin1_s = pins_sync[1];

  genvar g;
  generate
    for (g = 0; g < DCL_NCH; g = g + 1) begin : g_clamp
      dcl_code_clamp u_clamp (
        .code_in(buf_r[g]),
        .ceil_field(ceil_r[g]),
        .code_out(clamped[g]),
        .clipped(clip_now[g])
      );
      assign active_code[g*DCL_CODE_W +: DCL_CODE_W] = act_r[g];
    end
  endgenerate

  // current pair of ceiling fields, odd channel in the upper field
  always_comb begin
    ceil_word = '0;
    ceil_word[DCL_CEIL_LO_LSB +: DCL_LIM_W] = ceil_r[{ceil_pair, 1'b0}];
    ceil_word[DCL_CEIL_HI_LSB +: DCL_LIM_W] = ceil_r[{ceil_pair, 1'b1}];
  end

  assign ceil_new = dcl_merge(ceil_word, pwdata, pstrb);
  assign mask_new = dcl_merge(16'h0000, pwdata, pstrb);
  assign buf_new = dcl_merge({3'h0, buf_r[acc_ch]}, pwdata, pstrb);
  assign load_new = dcl_merge(16'h0000, pwdata, pstrb);

  // read mux; reserved bits read zero, bits above 15 too except the status clip field
  always_comb begin
    rd_nxt = '0;
    case (acc_kind)
      DCL_R_CEIL: begin
        rd_nxt[DCL_REG_W-1:0] = ceil_word;
      end
      DCL_R_MASK0: begin
        rd_nxt[DCL_NCH-1:0] = pin0_mask_r;
      end
      DCL_R_MASK1: begin
        rd_nxt[DCL_NCH-1:0] = pin1_mask_r;
      end
      DCL_R_BUF: begin
        rd_nxt[DCL_CODE_W-1:0] = buf_r[acc_ch];
      end
      DCL_R_ACT: begin
        rd_nxt[DCL_CODE_W-1:0] = act_r[acc_ch];
      end
      DCL_R_STAT: begin
        rd_nxt[DCL_STAT_SW_LSB +: DCL_NCH] = sw_r;
        rd_nxt[DCL_STAT_PIN0_BIT] = pin0_s;
        rd_nxt[DCL_STAT_PIN1_BIT] = pin1_s;
        rd_nxt[DCL_STAT_CLIP_LSB +: DCL_NCH] = clip_r;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  // zero-wait slave: answer prepared in setup, pready high in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (setup_phase) begin
      pready_r <= 1'b1;
      pslverr_r <= (acc_kind == DCL_R_NONE) ||
                   (pwrite && (acc_kind == DCL_R_ACT ||
                               acc_kind == DCL_R_STAT));
      prdata_r <= pwrite ? '0 : rd_nxt;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ceiling fields, all ones after reset so the range is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DCL_NCH; i++) begin
        ceil_r[i] <= DCL_CEIL_FIELD_RST;
      end
    end else if (wr_take && acc_kind == DCL_R_CEIL) begin
      ceil_r[{ceil_pair, 1'b0}] <=
        ceil_new[DCL_CEIL_LO_LSB +: DCL_LIM_W];
      ceil_r[{ceil_pair, 1'b1}] <=
        ceil_new[DCL_CEIL_HI_LSB +: DCL_LIM_W];
    end
  end

  // switch-pin masks, bit k is channel k (group a 0-3, group b 4-7)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_mask_r <= DCL_MASK_RST;
      pin1_mask_r <= DCL_MASK_RST;
    end else if (wr_take) begin
      if (acc_kind == DCL_R_MASK0) begin
        pin0_mask_r <= mask_new[DCL_NCH-1:0];
      end
      if (acc_kind == DCL_R_MASK1) begin
        pin1_mask_r <= mask_new[DCL_NCH-1:0];
      end
    end
  end

  // buffer codes, bits 15-13 dropped as reserved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DCL_NCH; i++) begin
        buf_r[i] <= DCL_CODE_RST;
      end
    end else if (wr_take && acc_kind == DCL_R_BUF) begin
      buf_r[acc_ch] <= buf_new[DCL_CODE_W-1:0];
    end
  end

  // transfer to active, clamped against the ceiling as it latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DCL_NCH; i++) begin
        act_r[i] <= DCL_CODE_RST;
      end
      clip_r <= '0;
    end else if (wr_take && acc_kind == DCL_R_LOAD) begin
      for (int i = 0; i < DCL_NCH; i++) begin
        if (load_new[i]) begin
          act_r[i] <= clamped[i];
          clip_r[i] <= clip_now[i];
        end
      end
    end
  end

  // unmasked pins are ignored; either enabled pin closes the switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_r <= '0;
    end else begin
      sw_r <= ({DCL_NCH{pin0_s}} & pin0_mask_r) |
              ({DCL_NCH{pin1_s}} & pin1_mask_r);
    end
  end

  assign switch_on = sw_r;

endmodule : dcl_regs

/* rtl/dcl_sync2.sv */
`timescale 1ns/10ps
module dcl_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : dcl_sync2

/* test/dcl_regs_sva.sv */
`timescale 1ns/10ps
module dcl_regs_sva
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DCL_ADDR_W-1:0] paddr,
  input wire logic [DCL_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [DCL_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic switch_ctrl_pin_zero,
  input wire logic switch_ctrl_pin_one,
  input wire logic [DCL_NCH-1:0] switch_on,
  input wire logic [DCL_NCH*DCL_CODE_W-1:0] active_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [7:0] idx = paddr[9:2];
  wire rd = pready && !pwrite && !pslverr;
  wire ldw = pready && pwrite && idx == DCL_IDX_LOAD;
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  AST_RDY_SRC: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  AST_IDLE: assert property (!pready |-> prdata == '0 && !pslverr)
    else $error("read bus not quiet");
  AST_REFUSE: assert property (pready && paddr[11:10] != 2'h0
    |-> pslverr && prdata == '0) else $error("unmapped not refused");
  AST_RO_ERR: assert property (pready && pwrite && idx[7:3] == 5'h0c
    |-> pslverr) else $error("active write accepted");
  AST_CEIL_RSV: assert property (rd && idx[7:2] == 6'h13 |->
    (prdata & ~32'h3f3f) == '0) else $error("ceiling spare bits set");
  AST_MASK_RSV: assert property (rd && idx[7:1] == 7'h28 |->
    prdata[31:8] == '0) else $error("mask spare bits set");
  AST_ACT_SRC: assert property ($changed(active_code) |->
    $past(ldw) || $past(ldw, 2)) else $error("active moved without load");
  AST_SW_OFF: assert property (
    (!switch_ctrl_pin_zero && !switch_ctrl_pin_one)[*4] |=> switch_on == '0)
    else $error("switch closed with pins low");
  cover property (pready && pslverr);
  cover property (ldw);
  cover property ($rose(switch_on[7]));
endmodule : dcl_regs_sva

/* test/dcl_regs_tb.sv */
`timescale 1ns/10ps
module dcl_regs_tb import dcl_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d, r;
  logic [3:0] pstrb = 4'hf, s;
  logic switch_ctrl_pin_zero = 1'b0, switch_ctrl_pin_one = 1'b0;
  logic pready, pslverr, e;
  logic [7:0] switch_on, ld, cl;
  logic [103:0] active_code;
  logic [15:0] ce[4], mk;
  logic [12:0] bf[8], ac[8];
  int fails = 0, checked = 0, seed = 32'h1eb5;
  always #4 pclk = ~pclk;
  dcl_regs u_dcl_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_ctrl_pin_zero(switch_ctrl_pin_zero),
    .switch_ctrl_pin_one(switch_ctrl_pin_one),
    .switch_on(switch_on), .active_code(active_code)
  );
  function automatic logic [12:0] cap(int k);
    return {ce[k/2][(k%2)*8 +: 6], 7'h7f};
  endfunction : cap
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [9:0] i, logic [31:0] dd, logic [3:0] st);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= dd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n == 20) begin
      fails++;
      stop_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task stop_test;
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    fails++;
    stop_test;
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ce[j]) ce[j] = 16'h3f3f;
      cl = '0;
      for (int j = 0; j < 6; j++) begin
        apb(0, 10'(DCL_IDX_CEIL_A_LO + j), '0, 4'hf);
        chk("rst", j < 4 ? 32'h3f3f : 32'h0, r);
        chk("rerr", 32'h0, {31'h0, e});
      end
      foreach (ac[k]) ac[k] = '0;
      for (int t = 0; t < 6; t++) begin
        for (int j = 0; j < 4; j++) begin
          d = t == 0 ? 32'h0 : $random(seed);
          s = t == 0 ? 4'hf : 4'($random(seed));
          apb(1, 10'(DCL_IDX_CEIL_A_LO + j), d, s);
          mk = {{8{s[1]}}, {8{s[0]}}};
          ce[j] = (ce[j] & ~mk) | (d[15:0] & mk & 16'h3f3f);
          apb(0, 10'(DCL_IDX_CEIL_A_LO + j), '0, 4'hf);
          chk("ceil", {16'h0, ce[j]}, r);
        end
        for (int k = 0; k < 8; k++) begin
          bf[k] = t % 3 == 0 ? 13'($random(seed)) : cap(k) + 13'(t % 3 - 1);
          apb(1, 10'(DCL_IDX_BUF_BASE + k), {19'h0, bf[k]}, 4'hf);
        end
        ld = 8'($random(seed));
        apb(1, 10'(DCL_IDX_LOAD), {24'h0, ld}, 4'hf);
        for (int k = 0; k < 8; k++) begin
          if (ld[k]) cl[k] = bf[k] > cap(k);
          if (ld[k]) ac[k] = bf[k] > cap(k) ? cap(k) : bf[k];
          apb(0, 10'(DCL_IDX_ACT_BASE + k), '0, 4'hf);
          chk("act", {19'h0, ac[k]}, r);
          chk("code", {19'h0, ac[k]}, 32'(active_code[13*k +: 13]));
        end
        apb(0, 10'(DCL_IDX_STATUS), '0, 4'hf);
        d = {8'h0, cl, 6'h0, switch_ctrl_pin_one, switch_ctrl_pin_zero, 8'h0};
        chk("stat", d, r);
      end
      for (int j = 0; j < 3; j++) begin
        apb(1, j == 0 ? 10'h052 : (j == 1 ? 10'h352 : 10'h060), '1, 4'hf);
        chk("err", 32'h1, {31'h0, e});
      end
      apb(0, 10'(DCL_IDX_ACT_BASE), '0, 4'hf);
      chk("keep", {19'h0, ac[0]}, r);
      for (int t = 0; t < 8; t++) begin
        d = $random(seed);
        apb(1, 10'(DCL_IDX_PIN0_MASK), d, 4'hf);
        apb(0, 10'(DCL_IDX_PIN0_MASK), '0, 4'hf);
        chk("mask0", {24'h0, d[7:0]}, r);
        apb(1, 10'(DCL_IDX_PIN1_MASK), d >> 8, 4'hf);
        apb(0, 10'(DCL_IDX_PIN1_MASK), '0, 4'hf);
        chk("mask1", {24'h0, d[15:8]}, r);
        switch_ctrl_pin_zero <= d[16];
        switch_ctrl_pin_one <= d[17];
        repeat (5) @(posedge pclk);
        mk = {8'h0, ({8{d[16]}} & d[7:0]) | ({8{d[17]}} & d[15:8])};
        chk("sw", {16'h0, mk}, {24'h0, switch_on});
      end
    end
    stop_test;
  end
endmodule : dcl_regs_tb
bind dcl_regs dcl_regs_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .switch_ctrl_pin_zero(switch_ctrl_pin_zero),
  .switch_ctrl_pin_one(switch_ctrl_pin_one),
  .switch_on(switch_on), .active_code(active_code)
);
